// ---- src/dis_pkg.sv ----
package dis_pkg;
    // ****************************************************************
    // Register map, byte addresses on the 32-bit bus.
    // ****************************************************************
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_USB_LIM = 8'h04;
    localparam logic [7:0] ADR_WALL_LIM = 8'h08;
    localparam logic [7:0] ADR_STATUS = 8'h0c;
    localparam logic [7:0] ADR_IRQ_STAT = 8'h10;
    localparam logic [7:0] ADR_IRQ_MASK = 8'h14;

    // Control register fields.
    localparam int CTRL_UVCL_DIS = 0;
    localparam int CTRL_LOCKOUT = 1;
    localparam int CTRL_BOOST_REQ = 2;
    localparam int CTRL_PRIORITY = 3;
    localparam int CTRL_W = 4;
    localparam logic [3:0] CTRL_RESET = 4'h0;

    // Current limit code width and the 100mA code.
    localparam int LIM_W = 5;
    localparam logic [4:0] LIM_100MA = 5'h01;

    // Status register fields.
    localparam int ST_USB_VALID = 0;
    localparam int ST_WALL_VALID = 1;
    localparam int ST_ID_GND = 2;
    localparam int ST_BAT_LOW = 3;
    localparam int ST_BOOST_RUN = 4;
    localparam int ST_BOOST_FAULT = 5;
    localparam int ST_USE_USB = 6;
    localparam int ST_USE_WALL = 7;
    localparam int STAT_W = 8;

    // Interrupt status and mask fields.
    localparam int IRQ_EXT_PWR = 0;
    localparam int IRQ_ID_CHG = 1;
    localparam int IRQ_FAULT = 2;
    localparam int IRQ_W = 3;
    localparam logic [2:0] IRQ_RESET = 3'h0;

    // Synchroniser vector positions for the comparator inputs.
    localparam int SI_USB_MIN = 0;
    localparam int SI_USB_MARGIN = 1;
    localparam int SI_USB_OV_OK = 2;
    localparam int SI_WALL_MIN = 3;
    localparam int SI_WALL_MARGIN = 4;
    localparam int SI_WALL_OV_OK = 5;
    localparam int SI_ID_GND = 6;
    localparam int SI_BAT_LOW = 7;
    localparam int SI_SHORT = 8;
    localparam int SI_SAG = 9;
    localparam int SI_AT_LIMIT = 10;
    localparam int SI_W = 11;

    // Short-circuit shutdown time and its cycle count.
    localparam longint CLK_HZ = 20_000_000;
    localparam longint FAULT_TIME_MS = 8;
    localparam int FAULT_CYC_DEF = int'(FAULT_TIME_MS * CLK_HZ / 1000);
    localparam int FAULT_CNT_W = 18;

    // Boost converter states.
    typedef enum logic [2:0] {
        BST_IDLE = 3'b001,
        BST_RUN = 3'b010,
        BST_FAULT = 3'b100
    } dis_boost_st_t;
endpackage : dis_pkg

// ---- src/dis_ctrl.sv ----
// Our own choices: register access over Wishbone and the register addresses.
`timescale 1ns/100ps
module dis_ctrl
    import dis_pkg::*;
#(
    parameter int FAULT_CYCLES = FAULT_CYC_DEF
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic usb_above_min_i,
    input wire logic usb_above_batt_i,
    input wire logic usb_below_ov_i,
    input wire logic wall_above_min_i,
    input wire logic wall_above_batt_i,
    input wire logic wall_below_ov_i,
    input wire logic id_grounded_i,
    input wire logic battery_low_i,
    input wire logic boost_short_i,
    input wire logic bus_sag_i,
    input wire logic input_at_limit_i,
    output logic [4:0] usb_side_current_limit_code_o,
    output logic [4:0] wall_side_current_limit_code_o,
    output logic use_usb_o,
    output logic use_wall_o,
    output logic boost_en_o,
    output logic charge_throttle_o,
    output logic power_reduce_o,
    output logic irq_o
);
    // ****************************************************************
    // Input synchroniser.
    // ****************************************************************
    logic [SI_W-1:0] raw_in;
    logic [SI_W-1:0] sync1_q;
    logic [SI_W-1:0] sync_q;

    assign raw_in = {input_at_limit_i, bus_sag_i, boost_short_i,
                     battery_low_i, id_grounded_i, wall_below_ov_i,
                     wall_above_batt_i, wall_above_min_i, usb_below_ov_i,
                     usb_above_batt_i, usb_above_min_i};

    // two-flop synchroniser
    // Only the second stage is read by the logic.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_q <= '0;
            sync_q <= '0;
        end else begin
            sync1_q <= raw_in;
            sync_q <= sync1_q;
        end
    end

    // ****************************************************************
    // Input qualification.
    // ****************************************************************
    logic usb_valid_q;
    logic wall_valid_q;
    logic id_q;
    logic bat_low_q;

    // three-condition input qualification
    // A USB or WALL input counts only when all three of its comparators agree.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            usb_valid_q <= 1'b0;
            wall_valid_q <= 1'b0;
            id_q <= 1'b0;
            bat_low_q <= 1'b0;
        end else begin
            usb_valid_q <= sync_q[SI_USB_MIN] & sync_q[SI_USB_MARGIN]
                           & sync_q[SI_USB_OV_OK];
            wall_valid_q <= sync_q[SI_WALL_MIN] & sync_q[SI_WALL_MARGIN]
                            & sync_q[SI_WALL_OV_OK];
            id_q <= sync_q[SI_ID_GND];
            bat_low_q <= sync_q[SI_BAT_LOW];
        end
    end

    // ****************************************************************
    // Bus slave.
    // ****************************************************************
    logic bus_req;
    logic wr_en;
    logic [CTRL_W-1:0] ctrl_q;
    logic [LIM_W-1:0] usb_lim_q;
    logic [LIM_W-1:0] wall_lim_q;
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_mask_q;
    logic [STAT_W-1:0] status;
    logic [31:0] rd_data;

    // A request is answered one cycle after it is first seen.
    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_en = bus_req & wb_we_i & wb_sel_i[0];

    // Read multiplexer; unmapped addresses read as zero.
    always_comb begin
        rd_data = '0;
        unique case (wb_adr_i)
            ADR_CTRL: rd_data[CTRL_W-1:0] = ctrl_q;
            ADR_USB_LIM: rd_data[LIM_W-1:0] = usb_lim_q;
            ADR_WALL_LIM: rd_data[LIM_W-1:0] = wall_lim_q;
            ADR_STATUS: rd_data[STAT_W-1:0] = status;
            ADR_IRQ_STAT: rd_data[IRQ_W-1:0] = irq_stat_q;
            ADR_IRQ_MASK: rd_data[IRQ_W-1:0] = irq_mask_q;
            default: rd_data = '0;
        endcase
    end

    // Acknowledge and read data register.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_req) begin
                wb_dat_o <= rd_data;
            end
        end
    end

    // Control and mask registers.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= CTRL_RESET;
            irq_mask_q <= IRQ_RESET;
        end else if (wr_en) begin
            if (wb_adr_i == ADR_CTRL) begin
                ctrl_q <= wb_dat_i[CTRL_W-1:0];
            end
            if (wb_adr_i == ADR_IRQ_MASK) begin
                irq_mask_q <= wb_dat_i[IRQ_W-1:0];
            end
        end
    end

    // ****************************************************************
    // Input current limit codes.
    // ****************************************************************
    logic usb_valid_d1_q;
    logic any_valid_d1_q;
    logic usb_lost;
    logic all_lost;

    assign usb_lost = usb_valid_d1_q & ~usb_valid_q;
    assign all_lost = any_valid_d1_q & ~(usb_valid_q | wall_valid_q);

    // Previous validity, used to spot a loss of power.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            usb_valid_d1_q <= 1'b0;
            any_valid_d1_q <= 1'b0;
        end else begin
            usb_valid_d1_q <= usb_valid_q;
            any_valid_d1_q <= usb_valid_q | wall_valid_q;
        end
    end

    // writable limit codes
    // A power loss wins over a host write in the same cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            usb_lim_q <= LIM_100MA;
            wall_lim_q <= LIM_100MA;
        end else begin
            if (usb_lost) begin
                usb_lim_q <= LIM_100MA;
            end else if (wr_en && wb_adr_i == ADR_USB_LIM) begin
                usb_lim_q <= wb_dat_i[LIM_W-1:0];
            end
            if (all_lost) begin
                wall_lim_q <= LIM_100MA;
            end else if (wr_en && wb_adr_i == ADR_WALL_LIM) begin
                wall_lim_q <= wb_dat_i[LIM_W-1:0];
            end
        end
    end

    // ****************************************************************
    // Boost converter control.
    // ****************************************************************
    dis_boost_st_t state_q;
    logic [FAULT_CNT_W-1:0] short_cnt_q;
    logic boost_ok;
    logic boost_want;
    logic short_done;

    assign boost_ok = ~usb_valid_q & ~wall_valid_q & ~bat_low_q;
    // host request overrides ID and lockout
    assign boost_want = ctrl_q[CTRL_BOOST_REQ]
                        | (id_q & ~ctrl_q[CTRL_LOCKOUT]);
    assign short_done = short_cnt_q
                        == FAULT_CNT_W'(FAULT_CYCLES - 1);

    // short-circuit timer
    // Counts consecutive short cycles while the converter runs.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            short_cnt_q <= '0;
        end else if (state_q == BST_RUN && sync_q[SI_SHORT]
                     && !short_done) begin
            short_cnt_q <= short_cnt_q + 1'b1;
        end else begin
            short_cnt_q <= '0;
        end
    end

    // Boost state machine; a fault holds until the start cause goes.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= BST_IDLE;
        end else begin
            unique case (state_q)
                BST_IDLE: begin
                    if (boost_ok && boost_want) begin
                        state_q <= BST_RUN;
                    end
                end
                BST_RUN: begin
                    if (!boost_ok || !boost_want) begin
                        state_q <= BST_IDLE;
                    end else if (short_done) begin
                        state_q <= BST_FAULT;
                    end
                end
                BST_FAULT: begin
                    if (!boost_want) begin
                        state_q <= BST_IDLE;
                    end
                end
                default: state_q <= BST_IDLE;
            endcase
        end
    end

    assign boost_en_o = state_q[1];

    // ****************************************************************
    // Input selection and regulation requests.
    // ****************************************************************
    // priority selection
    // boost drives the USB path only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            use_usb_o <= 1'b0;
            use_wall_o <= 1'b0;
        end else if (state_q == BST_RUN) begin
            use_usb_o <= 1'b1;
            use_wall_o <= 1'b0;
        end else if (usb_valid_q && wall_valid_q) begin
            use_usb_o <= ctrl_q[CTRL_PRIORITY];
            use_wall_o <= ~ctrl_q[CTRL_PRIORITY];
        end else begin
            use_usb_o <= usb_valid_q;
            use_wall_o <= wall_valid_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            charge_throttle_o <= 1'b0;
            power_reduce_o <= 1'b0;
        end else begin
            charge_throttle_o <= sync_q[SI_AT_LIMIT];
            power_reduce_o <= sync_q[SI_SAG] & ~ctrl_q[CTRL_UVCL_DIS];
        end
    end

    assign usb_side_current_limit_code_o = usb_lim_q;
    assign wall_side_current_limit_code_o = wall_lim_q;

    // ****************************************************************
    // Status and interrupts.
    // ****************************************************************
    logic id_d1_q;
    logic wall_valid_d1_q;
    logic [IRQ_W-1:0] irq_evt;
    logic [IRQ_W-1:0] irq_clr;

    always_comb begin
        status = '0;
        status[ST_USB_VALID] = usb_valid_q;
        status[ST_WALL_VALID] = wall_valid_q;
        status[ST_ID_GND] = id_q;
        status[ST_BAT_LOW] = bat_low_q;
        status[ST_BOOST_RUN] = state_q == BST_RUN;
        status[ST_BOOST_FAULT] = state_q == BST_FAULT;
        status[ST_USE_USB] = use_usb_o;
        status[ST_USE_WALL] = use_wall_o;
    end

    // Previous ID and WALL validity for change detection.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            id_d1_q <= 1'b0;
            wall_valid_d1_q <= 1'b0;
        end else begin
            id_d1_q <= id_q;
            wall_valid_d1_q <= wall_valid_q;
        end
    end

    always_comb begin
        irq_evt = '0;
        irq_evt[IRQ_EXT_PWR] = (usb_valid_q & ~usb_valid_d1_q)
                               | (wall_valid_q & ~wall_valid_d1_q);
        irq_evt[IRQ_ID_CHG] = id_q ^ id_d1_q;
        irq_evt[IRQ_FAULT] = (state_q == BST_RUN) & short_done;
    end

    assign irq_clr = (wr_en && wb_adr_i == ADR_IRQ_STAT)
                     ? wb_dat_i[IRQ_W-1:0] : '0;

    // Sticky status; a new event wins over a clear by writing one.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_q <= IRQ_RESET;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_evt;
        end
    end

    // Level interrupt from unmasked status bits.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_stat_q & irq_mask_q);
        end
    end

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    a_usb_lim_back: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $fell(usb_valid_q) |=> usb_lim_q == LIM_100MA)
        else $error("USB limit not restored after loss");

    a_wall_lim_back: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $past(usb_valid_q | wall_valid_q) && !usb_valid_q
        && !wall_valid_q |=> wall_lim_q == LIM_100MA)
        else $error("WALL limit not restored after total loss");

    a_wall_lim_keep: assert property (
        @(posedge clk_i) disable iff (rst_i)
        usb_valid_q && wall_valid_q && !wr_en ##1 !usb_valid_q
        && wall_valid_q && !wr_en |=> $stable(wall_lim_q))
        else $error("WALL limit changed on USB loss only");

    a_uvcl_reduce: assert property (
        @(posedge clk_i) disable iff (rst_i)
        sync_q[SI_SAG] |=> power_reduce_o == !$past(ctrl_q[CTRL_UVCL_DIS]))
        else $error("Undervoltage limit request wrong");

    a_auto_start: assert property (
        @(posedge clk_i) disable iff (rst_i)
        state_q == BST_IDLE && id_q && !ctrl_q[CTRL_LOCKOUT] && boost_ok
        |=> boost_en_o)
        else $error("Boost did not start from ID");

    a_lockout_hold: assert property (
        @(posedge clk_i) disable iff (rst_i)
        state_q == BST_IDLE && ctrl_q[CTRL_LOCKOUT]
        && !ctrl_q[CTRL_BOOST_REQ] |=> !boost_en_o)
        else $error("Boost started despite lockout");

    a_req_start: assert property (
        @(posedge clk_i) disable iff (rst_i)
        state_q == BST_IDLE && ctrl_q[CTRL_BOOST_REQ] && boost_ok
        |=> boost_en_o)
        else $error("Boost request not honoured");

    a_boost_inhibit: assert property (
        @(posedge clk_i) disable iff (rst_i)
        usb_valid_q || wall_valid_q || bat_low_q |=> !boost_en_o)
        else $error("Boost running while inhibited");

    a_fault_stop: assert property (
        @(posedge clk_i) disable iff (rst_i)
        state_q == BST_RUN && boost_ok && boost_want && short_done
        |=> !boost_en_o && status[ST_BOOST_FAULT]
        && irq_stat_q[IRQ_FAULT])
        else $error("Short did not stop boost with fault");

    a_id_irq: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $changed(id_q) |=> irq_stat_q[IRQ_ID_CHG])
        else $error("ID change did not set its event");

    a_valid_qual: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !sync_q[SI_USB_OV_OK] |=> !usb_valid_q)
        else $error("Overvoltage input counted valid");

    a_wall_first: assert property (
        @(posedge clk_i) disable iff (rst_i)
        usb_valid_q && wall_valid_q && state_q != BST_RUN
        |=> use_wall_o != $past(ctrl_q[CTRL_PRIORITY])
        && use_usb_o == $past(ctrl_q[CTRL_PRIORITY]))
        else $error("Priority selection wrong");

    a_boost_usb: assert property (
        @(posedge clk_i) disable iff (rst_i)
        boost_en_o |=> use_usb_o && !use_wall_o)
        else $error("Boost fed the WALL path");

    a_irq_level: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ##1 irq_o == |($past(irq_stat_q) & $past(irq_mask_q)))
        else $error("Interrupt output disagrees with status");
endmodule : dis_ctrl

// ---- tb/dis_front_model.sv ----
`timescale 1ns/100ps
module dis_front_model
    import dis_pkg::*;
(
    input wire logic clk_i,
    input wire logic [8:0] cmd_i,
    output logic [SI_W-1:0] cmp_o
);
    // ****************************************************************
    // Comparator front end
    // ****************************************************************
    // Comparator outputs move just after an edge, unrelated to the bus.
    // Three validity conditions.
    always_ff @(posedge clk_i) begin
        cmp_o[SI_USB_MIN] <= cmd_i[0];
        cmp_o[SI_USB_MARGIN] <= cmd_i[0];
        cmp_o[SI_USB_OV_OK] <= ~cmd_i[1];
        cmp_o[SI_WALL_MIN] <= cmd_i[2];
        cmp_o[SI_WALL_MARGIN] <= cmd_i[2];
        cmp_o[SI_WALL_OV_OK] <= ~cmd_i[3];
        cmp_o[SI_ID_GND] <= cmd_i[4];
        cmp_o[SI_BAT_LOW] <= cmd_i[5];
        cmp_o[SI_SHORT] <= cmd_i[6];
        cmp_o[SI_SAG] <= cmd_i[7];
        cmp_o[SI_AT_LIMIT] <= cmd_i[8];
    end
endmodule : dis_front_model

// ---- tb/tb_dis_ctrl.sv ----
`timescale 1ns/100ps
module tb_dis_ctrl
    import dis_pkg::*;
;
    // ****************************************************************
    // Bench signals
    // ****************************************************************
    localparam int FC = 20;
    localparam int C_U = 0, C_UOV = 1, C_W = 2, C_ID = 4, C_LB = 5;
    localparam int C_SH = 6, C_SG = 7, C_AL = 8;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hf;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic ack, irq, thr, prd, use_u, use_w, bst;
    logic [4:0] ulim, wlim, lu, lw;
    logic [8:0] cmd = 9'h000;
    logic [SI_W-1:0] cmp;
    logic uv = 0, wv = 0, id = 0, bl = 0, run = 0, flt = 0, prio = 0;
    int failures = 0, n_compared = 0, seed = 31058;

    // Free running 20 MHz clock.
    always #25 clk_i = ~clk_i;

    dis_front_model i_dis_front_model (.clk_i(clk_i), .cmd_i(cmd),
        .cmp_o(cmp));
    dis_ctrl #(.FAULT_CYCLES(FC)) i_dis_ctrl (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .usb_above_min_i(cmp[SI_USB_MIN]),
        .usb_above_batt_i(cmp[SI_USB_MARGIN]),
        .usb_below_ov_i(cmp[SI_USB_OV_OK]),
        .wall_above_min_i(cmp[SI_WALL_MIN]),
        .wall_above_batt_i(cmp[SI_WALL_MARGIN]),
        .wall_below_ov_i(cmp[SI_WALL_OV_OK]),
        .id_grounded_i(cmp[SI_ID_GND]), .battery_low_i(cmp[SI_BAT_LOW]),
        .boost_short_i(cmp[SI_SHORT]), .bus_sag_i(cmp[SI_SAG]),
        .input_at_limit_i(cmp[SI_AT_LIMIT]),
        .usb_side_current_limit_code_o(ulim),
        .wall_side_current_limit_code_o(wlim), .use_usb_o(use_u),
        .use_wall_o(use_w), .boost_en_o(bst), .charge_throttle_o(thr),
        .power_reduce_o(prd), .irq_o(irq));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Expected {wall, usb} path; boost always feeds the USB side.
    function automatic logic [1:0] exp_use(logic u, logic w, logic p,
        logic b);
        if (b) return 2'b01;
        if (u && w) return p ? 2'b01 : 2'b10;
        return {w, u};
    endfunction : exp_use

    task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    // One classic cycle; the request holds until ack is seen high.
    task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
        int n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n >= 50) failures++;
    endtask : wb

    task automatic wr(logic [7:0] a, logic [31:0] d);
        wb(1'b1, a, d);
        repeat (8) @(posedge clk_i);
    endtask : wr

    task automatic rdc(string nm, logic [7:0] a, logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(nm, q, e);
    endtask : rdc

    // Change one analog condition and let the synchronisers settle.
    task automatic drv(int i, logic v);
        @(posedge clk_i);
        cmd[i] <= v;
        repeat (8) @(posedge clk_i);
    endtask : drv

    task automatic chk_all();
        logic [1:0] p;
        p = exp_use(uv, wv, prio, run);
        rdc("status", ADR_STATUS, {24'h0, p, flt, run, bl, id, wv, uv});
        chk("paths", {29'h0, use_w, use_u, bst}, {29'h0, p, run});
    endtask : chk_all

    task automatic stop_test();
        $display("Compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    // Watchdog cuts a hang short.
    initial begin
        repeat (8000) @(posedge clk_i);
        failures++;
        stop_test();
    end

    // Main sequence.
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("lims", {22'h0, ulim, wlim},
            {22'h0, LIM_100MA, LIM_100MA});
        rdc("ctrl", ADR_CTRL, 32'(CTRL_RESET));
        rdc("mask", ADR_IRQ_MASK, 32'(IRQ_RESET));
        rdc("unmapped", 8'h18, 32'h0);
        for (int k = 0; k < 3; k++) begin
            lu = 5'(2 + {$random(seed)} % 30);
            lw = 5'(2 + {$random(seed)} % 30);
            wr(ADR_USB_LIM, 32'(lu));
            wr(ADR_WALL_LIM, 32'(lw));
            rdc("usb_lim", ADR_USB_LIM, 32'(lu));
            rdc("wall_lim", ADR_WALL_LIM, 32'(lw));
            chk("lim_out", {22'h0, ulim, wlim}, {22'h0, lu, lw});
        end
        // A write without the low byte lane is ignored.
        @(posedge clk_i);
        sel <= 4'he;
        wr(ADR_USB_LIM, 32'h1f);
        sel <= 4'hf;
        chk("sel_refused", 32'(ulim), 32'(lu));
        wr(ADR_IRQ_MASK, 32'h7);
        drv(C_U, 1'b1);
        uv = 1;
        chk_all();
        rdc("irq_stat", ADR_IRQ_STAT, 32'h1);
        chk("irq", 32'(irq), 32'h1);
        wr(ADR_IRQ_STAT, 32'h7);
        chk("irq", 32'(irq), 32'h0);
        drv(C_W, 1'b1);
        wv = 1;
        chk_all();
        wr(ADR_CTRL, 32'(1 << CTRL_PRIORITY));
        prio = 1;
        chk_all();
        // Limit codes fall back on loss.
        drv(C_UOV, 1'b1);
        uv = 0;
        chk_all();
        chk("lims", {22'h0, ulim, wlim},
            {22'h0, LIM_100MA, lw});
        drv(C_W, 1'b0);
        wv = 0;
        chk("wall_lim", 32'(wlim), 32'(LIM_100MA));
        drv(C_U, 1'b0);
        drv(C_UOV, 1'b0);
        drv(C_AL, 1'b1);
        drv(C_SG, 1'b1);
        chk("thr_prd", {30'h0, thr, prd}, 32'h3);
        wr(ADR_CTRL, 32'h3);
        prio = 0;
        chk("prd", 32'(prd), 32'h0);
        drv(C_AL, 1'b0);
        drv(C_SG, 1'b0);
        chk("thr", 32'(thr), 32'h0);
        // ID start with and without lockout.
        wr(ADR_IRQ_STAT, 32'h7);
        drv(C_ID, 1'b1);
        id = 1;
        chk_all();
        rdc("irq_stat", ADR_IRQ_STAT, 32'h2);
        wr(ADR_CTRL, 32'(1 << CTRL_PRIORITY));
        prio = 1;
        run = 1;
        chk_all();
        drv(C_W, 1'b1);
        wv = 1;
        run = 0;
        chk_all();
        drv(C_W, 1'b0);
        wv = 0;
        run = 1;
        chk_all();
        drv(C_LB, 1'b1);
        bl = 1;
        run = 0;
        chk_all();
        drv(C_LB, 1'b0);
        bl = 0;
        drv(C_ID, 1'b0);
        id = 0;
        chk_all();
        // Host request ignores ID and lockout.
        wr(ADR_CTRL, 32'h6);
        prio = 0;
        run = 1;
        chk_all();
        wr(ADR_CTRL, 32'h0);
        run = 0;
        chk_all();
        wr(ADR_CTRL, 32'h4);
        wr(ADR_IRQ_STAT, 32'h7);
        @(posedge clk_i);
        cmd[C_SH] <= 1'b1;
        repeat (FC + 10) @(posedge clk_i);
        flt = 1;
        chk_all();
        rdc("irq_stat", ADR_IRQ_STAT, 32'h4);
        drv(C_SH, 1'b0);
        wr(ADR_CTRL, 32'h0);
        flt = 0;
        chk_all();
        // A reset with boost stopped brings the USB limit code and the control register back.
        wr(ADR_USB_LIM, 32'h1f);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("rst_lim", 32'(ulim), 32'(LIM_100MA));
        rdc("rst_ctrl", ADR_CTRL, 32'(CTRL_RESET));
        stop_test();
    end
endmodule : tb_dis_ctrl
